// [common/fieldbus_sup_pkg.sv]
// Constants, modes and carriers of the fieldbus supervisor.
// Assumes one 50 MHz clock and a 32-bit APB port.
package fieldbus_sup_pkg;

    localparam int CLK_HZ         = 50_000_000;
    localparam int CLK_MHZ        = CLK_HZ / 1_000_000;

    // Times and their cycle counts.
    localparam int FDET_TIME_US   = 200;
    localparam int FDET_CYC       = FDET_TIME_US * CLK_MHZ;
    localparam int FDET_SPLIT_MHZ = 12;
    localparam int FDET_EDGE_THR  = FDET_TIME_US * FDET_SPLIT_MHZ;
    localparam int WDOG_TIME_US   = 20;
    localparam int WDOG_CYC       = WDOG_TIME_US * CLK_MHZ;
    localparam int OT_TIME_S      = 2;
    localparam int OT_CYC         = OT_TIME_S * CLK_HZ;
    localparam int BIT_TIME_NS    = 6000;
    localparam int CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;
    localparam int HALF_BIT_CYC   = BIT_TIME_NS / 2 / CLK_PERIOD_NS;

    localparam int FDET_W = $clog2(FDET_CYC + 1);
    localparam int OT_W   = $clog2(OT_CYC + 1);
    localparam int WDOG_W = $clog2(WDOG_CYC + 1);
    localparam int HALF_W = $clog2(HALF_BIT_CYC + 1);
    localparam int TELE_W = 14;
    localparam int FRAME_BITS = 7;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_RESP   = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_RXDATA = 8'h0C;
    localparam logic [7:0] OFS_PARAM  = 8'h10;

    // Control fields.
    localparam int CTRL_MASTER   = 0;
    localparam int CTRL_REPEATER = 1;
    localparam int CTRL_REINIT   = 2;
    localparam logic CTRL_MASTER_RST   = 1'b0;
    localparam logic CTRL_REPEATER_RST = 1'b0;

    // Status fields.
    localparam int ST_MODE     = 0;
    localparam int ST_CLK16    = 2;
    localparam int ST_LOCK     = 3;
    localparam int ST_SHUTDOWN = 4;
    localparam int ST_WDOG     = 5;
    localparam int ST_BUSY     = 6;
    localparam int ST_MFI      = 7;
    localparam int ST_THR      = 8;

    // Telegram opcode field and codes.
    localparam int OP_MSB = 13;
    localparam int OP_LSB = 12;
    localparam logic [1:0] OP_DATA = 2'h0;
    localparam logic [1:0] OP_NVWR = 2'h1;

    typedef enum logic [1:0] {
        MODE_SLAVE,
        MODE_MASTER,
        MODE_REPEATER,
        MODE_MONITOR
    } op_mode_e;

    typedef enum logic [1:0] {
        MSM_IDLE,
        MSM_DECODE,
        MSM_RESPOND,
        MSM_WAIT_TX
    } msm_state_e;

    typedef struct packed {
        logic              done;
        logic              ok;
        logic              from_master;
        logic [TELE_W-1:0] data;
    } telegram_s;

endpackage

// [hdl/fieldbus_mode_clock_supervisor.sv]
// Mode select, clock supervision, shutdown latch, telegram flow.
// Decoder and front ends share pclk; pins are synchronised here.
// presetn is the power-on reset.
//
// Functional notes
// - Flags 00 slave, 10 master, 11 repeater, 01 monitor.
// - Flags reloaded at each initialization only.
// - Start at 16 MHz; after 200 us keep or go to 8 MHz.
// - Frequency detection frozen after first good telegram.
// - Only power-on reset unfreezes it.
// - Over 20 us without oscillation forces device reset.
// - Watchdog reset holds until oscillation returns.
// - Overheat over 2 s: inductor off, reset, analog power-down.
// - Shutdown latched until supply cycling.
// - Output short to ground shuts down likewise.
// - NV writes and I/O only in slave mode.
// - Slave strobes only after correct telegrams.
// - State machine decodes, acts, returns response by register.
// - Response sent as Manchester-II stream.
// - Thresholds at half the first pulse amplitude.
// - Master strobes once per good slave response.
// - Monitor strobes master and slave telegrams separately.
// - Addressing pin is telegram input in slave, transmitter in master.
// - Multi-function pin digital in slave, power-fail analog in master.
// - Repeater and monitor: master variants, own parameter port.
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module fieldbus_mode_clock_supervisor #(
    parameter int FDET_CYC_P = fieldbus_sup_pkg::FDET_CYC,
    parameter int OT_CYC_P   = fieldbus_sup_pkg::OT_CYC
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic                             pready,
    output logic [31:0]                      prdata,
    output logic                             pslverr,
    input  wire logic                        osc_activity,
    input  wire logic                        overtemp,
    input  wire logic                        regulated_out_short,
    input  wire logic                        addr_channel_in,
    input  wire logic                        multi_function_in,
    input  wire fieldbus_sup_pkg::telegram_s telegram,
    input  wire logic                        first_pulse_valid,
    input  wire logic [2:0]                  first_pulse_code,
    output logic [2:0]                       comp_threshold,
    output logic                             rx_strobe_a,
    output logic                             rx_strobe_b,
    output logic                             rx_from_addr_channel,
    output logic                             tx_out,
    output logic                             tx_en,
    output logic [3:0]                       param_out,
    output logic [3:0]                       io_out,
    output logic                             nv_write,
    output logic                             clk_sel_16mhz,
    output logic                             device_reset,
    output logic                             inductor_en,
    output logic                             analog_power_down,
    output logic                             fid_analog_en
);

    localparam int NSYNC = 5;
    localparam int SY_OSC = 0;
    localparam int SY_OT  = 1;
    localparam int SY_SC  = 2;
    localparam int SY_ADR = 3;
    localparam int SY_MFI = 4;

    typedef struct packed {
        logic [NSYNC-1:0]                    s1;
        logic [NSYNC-1:0]                    s2;
        logic                                osc_prev;
        logic [fieldbus_sup_pkg::WDOG_W-1:0] wdog_cnt;
        logic                                wdog_rst;
        logic [fieldbus_sup_pkg::OT_W-1:0]   ot_cnt;
        logic                                shutdown;
        logic [fieldbus_sup_pkg::FDET_W-1:0] fdet_cnt;
        logic [fieldbus_sup_pkg::FDET_W-1:0] edge_cnt;
        logic                                clk16;
        logic                                locked;
        logic                                nv_master;
        logic                                nv_repeater;
        fieldbus_sup_pkg::op_mode_e          mode;
        logic                                reinit;
        logic                                dev_rst;
        logic [2:0]                          thr;
        fieldbus_sup_pkg::msm_state_e        msm;
        logic [fieldbus_sup_pkg::TELE_W-1:0] rxdata;
        logic [3:0]                          resp;
        logic [3:0]                          io;
        logic                                nv_wr;
        logic                                stb_a;
        logic                                stb_b;
        logic [3:0]                          param;
        logic                                enc_busy;
        logic                                enc_start;
        logic [2:0]                          enc_bit;
        logic                                enc_half;
        logic [fieldbus_sup_pkg::HALF_W-1:0] enc_cnt;
        logic [fieldbus_sup_pkg::FRAME_BITS-1:0] enc_sh;
        logic                                tx;
        logic                                tx_en;
        logic [31:0]                         rdata;
        logic                                slverr;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    logic       osc_edge;
    logic       ok_evt;
    logic       slave;
    logic       apb_setup;
    logic       apb_wr;
    logic [1:0] flags;

    function automatic fieldbus_sup_pkg::op_mode_e decode_mode(input logic [1:0] f);
        case (f)
            2'b00:   decode_mode = fieldbus_sup_pkg::MODE_SLAVE;
            2'b10:   decode_mode = fieldbus_sup_pkg::MODE_MASTER;
            2'b11:   decode_mode = fieldbus_sup_pkg::MODE_REPEATER;
            default: decode_mode = fieldbus_sup_pkg::MODE_MONITOR;
        endcase
    endfunction

    always_comb begin
        st_nxt    = st_r;
        osc_edge  = st_r.s2[SY_OSC] & ~st_r.osc_prev;
        slave     = (st_r.mode == fieldbus_sup_pkg::MODE_SLAVE);
        ok_evt    = telegram.done & telegram.ok & ~st_r.dev_rst;
        apb_setup = psel & ~penable;
        apb_wr    = psel & penable & pwrite;
        flags     = {st_r.nv_master, st_r.nv_repeater};

        // Pin synchronisers.
        st_nxt.s1 = {multi_function_in, addr_channel_in, regulated_out_short,
                     overtemp, osc_activity};
        st_nxt.s2 = st_r.s1;
        st_nxt.osc_prev = st_r.s2[SY_OSC];

        // Watchdog holds reset until an oscillator edge returns.
        if (osc_edge) begin
            st_nxt.wdog_cnt = '0;
            st_nxt.wdog_rst = 1'b0;
        end else if (st_r.wdog_cnt >= fieldbus_sup_pkg::WDOG_W'(fieldbus_sup_pkg::WDOG_CYC)) begin
            st_nxt.wdog_rst = 1'b1;
        end else begin
            st_nxt.wdog_cnt = st_r.wdog_cnt + 1'b1;
        end

        // Overheat or short, filtered, latched until power-on.
        if (st_r.s2[SY_OT] | st_r.s2[SY_SC]) begin
            if (st_r.ot_cnt >= fieldbus_sup_pkg::OT_W'(OT_CYC_P)) begin
                st_nxt.shutdown = 1'b1;
            end else begin
                st_nxt.ot_cnt = st_r.ot_cnt + 1'b1;
            end
        end else begin
            st_nxt.ot_cnt = '0;
        end

        // Frequency detection in repeated windows until locked.
        if (!st_r.locked) begin
            if (st_r.fdet_cnt >= fieldbus_sup_pkg::FDET_W'(FDET_CYC_P - 1)) begin
                st_nxt.fdet_cnt = '0;
                st_nxt.edge_cnt = '0;
                st_nxt.clk16 = (st_r.edge_cnt >=
                    fieldbus_sup_pkg::FDET_W'(fieldbus_sup_pkg::FDET_EDGE_THR));
            end else begin
                st_nxt.fdet_cnt = st_r.fdet_cnt + 1'b1;
                if (osc_edge) begin
                    st_nxt.edge_cnt = st_r.edge_cnt + 1'b1;
                end
            end
        end
        if (ok_evt) begin
            st_nxt.locked = 1'b1;
        end

        // Device reset reloads the mode from the flags.
        st_nxt.reinit  = 1'b0;
        st_nxt.dev_rst = st_r.wdog_rst | st_r.shutdown | st_r.reinit;
        if (st_r.dev_rst) begin
            st_nxt.mode = decode_mode(flags);
        end

        // Threshold at half the first-pulse amplitude.
        if (first_pulse_valid) begin
            st_nxt.thr = first_pulse_code >> 1;
        end

        // Receive strobes per mode, one cycle each.
        st_nxt.stb_a = 1'b0;
        st_nxt.stb_b = 1'b0;
        case (st_r.mode)
            fieldbus_sup_pkg::MODE_SLAVE:
                st_nxt.stb_a = ok_evt & telegram.from_master;
            fieldbus_sup_pkg::MODE_MONITOR: begin
                st_nxt.stb_a = ok_evt & telegram.from_master;
                st_nxt.stb_b = ok_evt & ~telegram.from_master;
            end
            default:
                st_nxt.stb_a = ok_evt & ~telegram.from_master;
        endcase

        // Main state machine, active in slave mode only.
        st_nxt.nv_wr     = 1'b0;
        st_nxt.enc_start = 1'b0;
        case (st_r.msm)
            fieldbus_sup_pkg::MSM_IDLE:
                if (slave && ok_evt && telegram.from_master) begin
                    st_nxt.rxdata = telegram.data;
                    st_nxt.msm    = fieldbus_sup_pkg::MSM_DECODE;
                end
            fieldbus_sup_pkg::MSM_DECODE: begin
                case (st_r.rxdata[fieldbus_sup_pkg::OP_MSB:fieldbus_sup_pkg::OP_LSB])
                    fieldbus_sup_pkg::OP_DATA:
                        st_nxt.io = st_r.rxdata[3:0];
                    fieldbus_sup_pkg::OP_NVWR: begin
                        st_nxt.nv_master   = st_r.rxdata[0];
                        st_nxt.nv_repeater = st_r.rxdata[1];
                        st_nxt.nv_wr       = 1'b1;
                    end
                    default: ;
                endcase
                st_nxt.msm = fieldbus_sup_pkg::MSM_RESPOND;
            end
            fieldbus_sup_pkg::MSM_RESPOND: begin
                st_nxt.enc_start = 1'b1;
                st_nxt.msm       = fieldbus_sup_pkg::MSM_WAIT_TX;
            end
            fieldbus_sup_pkg::MSM_WAIT_TX:
                if (!st_r.enc_busy && !st_r.enc_start) begin
                    st_nxt.msm = fieldbus_sup_pkg::MSM_IDLE;
                end
            default:
                st_nxt.msm = fieldbus_sup_pkg::MSM_IDLE;
        endcase

        // Manchester-II response encoder: start 0, four data, parity, stop 1.
        if (st_r.enc_start) begin
            st_nxt.enc_busy = 1'b1;
            st_nxt.enc_sh   = {1'b1, ^st_r.resp, st_r.resp, 1'b0};
            st_nxt.enc_bit  = '0;
            st_nxt.enc_half = 1'b0;
            st_nxt.enc_cnt  = '0;
        end else if (st_r.enc_busy) begin
            if (st_r.enc_cnt >=
                fieldbus_sup_pkg::HALF_W'(fieldbus_sup_pkg::HALF_BIT_CYC - 1)) begin
                st_nxt.enc_cnt  = '0;
                st_nxt.enc_half = ~st_r.enc_half;
                if (st_r.enc_half) begin
                    st_nxt.enc_sh = st_r.enc_sh >> 1;
                    if (st_r.enc_bit == 3'(fieldbus_sup_pkg::FRAME_BITS - 1)) begin
                        st_nxt.enc_busy = 1'b0;
                    end else begin
                        st_nxt.enc_bit = st_r.enc_bit + 1'b1;
                    end
                end
            end else begin
                st_nxt.enc_cnt = st_r.enc_cnt + 1'b1;
            end
        end

        // Transmit source: encoder in slave, addressing pin otherwise.
        if (slave) begin
            st_nxt.tx    = st_nxt.enc_busy & (st_nxt.enc_half ~^ st_nxt.enc_sh[0]);
            st_nxt.tx_en = st_nxt.enc_busy;
        end else begin
            st_nxt.tx    = st_r.s2[SY_ADR];
            st_nxt.tx_en = 1'b1;
        end

        // Parameter port content per mode.
        case (st_r.mode)
            fieldbus_sup_pkg::MODE_SLAVE:    st_nxt.param = st_r.param;
            fieldbus_sup_pkg::MODE_MASTER:   st_nxt.param = 4'h0;
            fieldbus_sup_pkg::MODE_REPEATER: st_nxt.param = {2'b00, st_r.tx_en, st_nxt.stb_a};
            default: st_nxt.param = {2'b00, st_nxt.stb_b, st_nxt.stb_a};
        endcase

        // APB: zero-wait slave, read data prepared in the setup cycle.
        if (apb_setup) begin
            st_nxt.rdata  = 32'h0000_0000;
            st_nxt.slverr = 1'b0;
            case (paddr)
                fieldbus_sup_pkg::OFS_CTRL: begin
                    st_nxt.rdata[fieldbus_sup_pkg::CTRL_MASTER]   = st_r.nv_master;
                    st_nxt.rdata[fieldbus_sup_pkg::CTRL_REPEATER] = st_r.nv_repeater;
                end
                fieldbus_sup_pkg::OFS_RESP:   st_nxt.rdata[3:0] = st_r.resp;
                fieldbus_sup_pkg::OFS_STATUS: begin
                    st_nxt.rdata[fieldbus_sup_pkg::ST_MODE +: 2]  = st_r.mode;
                    st_nxt.rdata[fieldbus_sup_pkg::ST_CLK16]      = st_r.clk16;
                    st_nxt.rdata[fieldbus_sup_pkg::ST_LOCK]       = st_r.locked;
                    st_nxt.rdata[fieldbus_sup_pkg::ST_SHUTDOWN]   = st_r.shutdown;
                    st_nxt.rdata[fieldbus_sup_pkg::ST_WDOG]       = st_r.wdog_rst;
                    st_nxt.rdata[fieldbus_sup_pkg::ST_BUSY]       =
                        (st_r.msm != fieldbus_sup_pkg::MSM_IDLE);
                    st_nxt.rdata[fieldbus_sup_pkg::ST_MFI]        = slave & st_r.s2[SY_MFI];
                    st_nxt.rdata[fieldbus_sup_pkg::ST_THR +: 3]   = st_r.thr;
                end
                fieldbus_sup_pkg::OFS_RXDATA:
                    st_nxt.rdata[fieldbus_sup_pkg::TELE_W-1:0] = st_r.rxdata;
                fieldbus_sup_pkg::OFS_PARAM:  st_nxt.rdata[3:0] = st_r.param;
                default: st_nxt.slverr = 1'b1;
            endcase
        end
        if (apb_wr) begin
            case (paddr)
                fieldbus_sup_pkg::OFS_CTRL: begin
                    if (slave) begin
                        st_nxt.nv_master   = pwdata[fieldbus_sup_pkg::CTRL_MASTER];
                        st_nxt.nv_repeater = pwdata[fieldbus_sup_pkg::CTRL_REPEATER];
                    end
                    st_nxt.reinit = pwdata[fieldbus_sup_pkg::CTRL_REINIT];
                end
                fieldbus_sup_pkg::OFS_RESP:  st_nxt.resp = pwdata[3:0];
                fieldbus_sup_pkg::OFS_PARAM:
                    if (slave) begin
                        st_nxt.param = pwdata[3:0];
                    end
                default: ;
            endcase
        end

        // Device reset idles the logic but keeps the frequency lock.
        if (st_r.dev_rst) begin
            st_nxt.msm      = fieldbus_sup_pkg::MSM_IDLE;
            st_nxt.enc_busy = 1'b0;
            st_nxt.tx       = 1'b0;
            st_nxt.tx_en    = 1'b0;
            st_nxt.io       = 4'h0;
            st_nxt.param    = 4'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r             <= '0;
            st_r.clk16       <= 1'b1;
            st_r.nv_master   <= fieldbus_sup_pkg::CTRL_MASTER_RST;
            st_r.nv_repeater <= fieldbus_sup_pkg::CTRL_REPEATER_RST;
            st_r.dev_rst     <= 1'b1;
            st_r.mode        <= fieldbus_sup_pkg::MODE_SLAVE;
            st_r.msm         <= fieldbus_sup_pkg::MSM_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pready = 1'b1;
    assign prdata = st_r.rdata;
    assign pslverr = st_r.slverr;
    assign comp_threshold = st_r.thr;
    assign rx_strobe_a = st_r.stb_a;
    assign rx_strobe_b = st_r.stb_b;
    assign rx_from_addr_channel = (st_r.mode == fieldbus_sup_pkg::MODE_SLAVE);
    assign tx_out = st_r.tx;
    assign tx_en = st_r.tx_en;
    assign param_out = st_r.param;
    assign io_out = st_r.io;
    assign nv_write = st_r.nv_wr;
    assign clk_sel_16mhz = st_r.clk16;
    assign device_reset = st_r.dev_rst;
    assign inductor_en = ~st_r.shutdown;
    assign analog_power_down = st_r.shutdown;
    assign fid_analog_en = (st_r.mode != fieldbus_sup_pkg::MODE_SLAVE);

endmodule

// [test/fieldbus_line_model.sv]
// Far side: crystal and decoder verdicts.
// send() is called just after a rising pclk edge.
`timescale 1ns/1ns
module fieldbus_line_model (
    input  wire logic                   pclk,
    input  wire logic                   osc_run,
    output logic                        osc_activity,
    output fieldbus_sup_pkg::telegram_s telegram
);
    initial begin
        osc_activity = 1'b0;
        telegram = '0;
    end
    // The crystal pin stands still while osc_run is low.
    always @(posedge pclk) if (osc_run) osc_activity <= ~osc_activity;
    // Outside done the fields show their inverse.
    task automatic send(input logic ok, input logic fm, input logic [13:0] d);
        telegram <= '{1'b1, ok, fm, d};
        @(posedge pclk);
        telegram <= '{1'b0, ~ok, ~fm, ~d};
    endtask
endmodule

// [test/fieldbus_sup_properties.sv]
// Checker on the supervisor's ports.
// Bound into every supervisor instance.
`timescale 1ns/1ns
module fieldbus_sup_properties (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        osc_activity,
    input wire fieldbus_sup_pkg::telegram_s telegram,
    input wire logic                        first_pulse_valid,
    input wire logic [2:0]                  first_pulse_code,
    input wire logic [2:0]                  comp_threshold,
    input wire logic                        rx_strobe_a,
    input wire logic                        rx_strobe_b,
    input wire logic                        tx_en,
    input wire logic                        nv_write,
    input wire logic                        clk_sel_16mhz,
    input wire logic                        device_reset,
    input wire logic                        inductor_en,
    input wire logic                        analog_power_down,
    input wire logic                        fid_analog_en
);
    logic        osc_q_r;
    logic [10:0] still_r;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Cycles since the oscillator pin last moved, saturating.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_q_r <= 1'b0;
            still_r <= '0;
        end else begin
            osc_q_r <= osc_activity;
            still_r <= (osc_activity != osc_q_r) ? '0 : still_r + {10'h000, still_r != 11'h7FF};
        end
    end
    sequence s_pulse;
        first_pulse_valid && !device_reset;
    endsequence
    a_strobe_a_pulse: assert property (rx_strobe_a |=> !rx_strobe_a)
        else $error("wide strobe");
    a_strobe_b_pulse: assert property (rx_strobe_b |=> !rx_strobe_b)
        else $error("wide strobe");
    a_strobe_cause: assert property (rx_strobe_a || rx_strobe_b |->
        $past(telegram.done && telegram.ok)) else $error("stray strobe");
    a_slave_strobe_mon: assert property (rx_strobe_b |->
        fid_analog_en && $past(!telegram.from_master)) else $error("stray strobe b");
    a_half_thr: assert property (s_pulse |=>
        comp_threshold == $past(first_pulse_code) >> 1) else $error("bad threshold");
    a_shut_outs: assert property (analog_power_down |-> !inductor_en ##1 device_reset)
        else $error("bad shutdown");
    a_shut_latch: assert property (analog_power_down |=> analog_power_down)
        else $error("shutdown lost");
    a_nv_slave: assert property (nv_write |-> !fid_analog_en && $past(telegram.done, 2))
        else $error("stray nv write");
    a_wdog_reset: assert property (still_r > 11'd1010 |-> device_reset)
        else $error("no watchdog reset");
    a_lock_freeze: assert property (rx_strobe_a |=> $stable(clk_sel_16mhz) [*8])
        else $error("clock moved");
    a_tx_master: assert property (fid_analog_en && $past(fid_analog_en) &&
        !$past(device_reset) && !device_reset |-> tx_en) else $error("no pass-through");
endmodule
bind fieldbus_mode_clock_supervisor fieldbus_sup_properties u_props (.*);

// [test/test_fieldbus_mode_clock_supervisor.sv]
// Self-checking bench for the supervisor.
// Package, model and checker compile first.
`timescale 1ns/1ns
module test_fieldbus_mode_clock_supervisor;
    localparam logic [7:0] ST = fieldbus_sup_pkg::OFS_STATUS;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, err, osc_run = 1'b1, overtemp = 1'b0, regulated_out_short = 1'b0;
    logic addr_channel_in = 1'b1, multi_function_in = 1'b0, first_pulse_valid = 1'b0;
    logic tx_out, tx_en, nv_write, clk_sel_16mhz, device_reset, osc_activity, rx_from_addr_channel;
    logic rx_strobe_a, rx_strobe_b, inductor_en, analog_power_down, fid_analog_en;
    logic [2:0]  first_pulse_code = 3'h0, comp_threshold;
    logic [3:0]  io_out, param_out;
    logic [6:0]  frame = 7'h4A;
    fieldbus_sup_pkg::telegram_s telegram;
    int n_mismatch = 0, checked = 0, cyc = 0, cnt_a = 0, cnt_b = 0, cnt_nv = 0, ba, bb, bn;
    fieldbus_mode_clock_supervisor #(.FDET_CYC_P(200), .OT_CYC_P(50)) DUT (.*);
    fieldbus_line_model u_line (.*);
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        cnt_a <= cnt_a + rx_strobe_a;
        cnt_b <= cnt_b + rx_strobe_b;
        cnt_nv <= cnt_nv + nv_write;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic power_on();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask
    task automatic tele(input logic ok, input logic fm, input logic [13:0] d);
        @(posedge pclk);
        u_line.send(ok, fm, d);
        repeat (4) @(posedge pclk);
    endtask
    initial begin
        power_on();
        apb(1'b0, ST, 32'h0);
        chk("status", rd & 32'h0000_003F, 32'h0000_0004);
        first_pulse_code <= 3'h7;
        first_pulse_valid <= 1'b1;
        @(posedge pclk);
        first_pulse_valid <= 1'b0;
        apb(1'b0, ST, 32'h0);
        chk("threshold", {29'h0, rd[10:8]}, 32'h3);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
        repeat (300) @(posedge pclk);
        chk("clk16", clk_sel_16mhz, 32'h0);
        apb(1'b1, fieldbus_sup_pkg::OFS_RESP, 32'h5);
        tele(1'b0, 1'b1, 14'h000A);
        chk("bad telegram", cnt_a, 32'h0);
        $display("test basics done");
        @(posedge pclk);
        u_line.send(1'b1, 1'b1, 14'h000A);
        for (int k = 0; k < 20 && tx_en !== 1'b1; k++) @(negedge pclk);
        for (int i = 0; i < 7; i++) begin
            repeat (75) @(negedge pclk);
            chk("tx half 1", tx_out, {31'h0, ~frame[i]});
            repeat (150) @(negedge pclk);
            chk("tx half 2", tx_out, {31'h0, frame[i]});
            repeat (75) @(negedge pclk);
        end
        repeat (10) @(negedge pclk);
        chk("tx end", {tx_en, io_out}, 32'hA);
        chk("strobes", cnt_a, 32'h1);
        apb(1'b0, ST, 32'h0);
        chk("lock", rd[3], 32'h1);
        $display("test slave frame done");
        for (int m = 0; m < 4; m++) begin
            power_on();
            ba = cnt_a;
            bb = cnt_b;
            bn = cnt_nv;
            apb(1'b1, fieldbus_sup_pkg::OFS_CTRL, {30'h0, 2'(m ^ (m >> 1))});
            apb(1'b0, ST, 32'h0);
            chk("early mode", rd[1:0], 32'h0);
            apb(1'b1, fieldbus_sup_pkg::OFS_CTRL, {29'h0, 1'b1, 2'(m ^ (m >> 1))});
            repeat (4) @(posedge pclk);
            apb(1'b0, ST, 32'h0);
            chk("mode", rd[1:0], m);
            chk("pins", {param_out, fid_analog_en, rx_from_addr_channel, tx_out},
                {2'b00, m == 2, 1'b0, m != 0, m == 0, m != 0});
            tele(1'b1, 1'b0, 14'h0000);
            chk("strobe a", cnt_a - ba, m == 1 || m == 2);
            tele(1'b1, 1'b1, 14'h1000);
            chk("strobe b", cnt_b - bb, m == 3);
            chk("nv write", cnt_nv - bn, m == 0);
        end
        $display("test modes done");
        osc_run <= 1'b0;
        repeat (1100) @(posedge pclk);
        chk("watchdog", device_reset, 32'h1);
        osc_run <= 1'b1;
        repeat (20) @(posedge pclk);
        chk("watchdog release", device_reset, 32'h0);
        for (int j = 0; j < 2; j++) begin
            power_on();
            {overtemp, regulated_out_short} <= 2'b10 >> j;
            repeat (30) @(posedge pclk);
            chk("early shutdown", analog_power_down, 32'h0);
            repeat (50) @(posedge pclk);
            chk("shutdown", {analog_power_down, inductor_en, device_reset}, 32'h5);
            {overtemp, regulated_out_short} <= 2'b00;
            repeat (10) @(posedge pclk);
            chk("latched", analog_power_down, 32'h1);
        end
        power_on();
        chk("supply cycle", analog_power_down, 32'h0);
        $display("test supervision done");
        stop_test();
    end
endmodule
